// file: design/wocw_pkg.sv
// Constants, field layouts and carriers for the write-once option bank
// and watchdog. Assumes one system clock and a crystal tick enable.
package wocw_pkg;

  localparam logic [15:0] OFS_OPT_TWO  = 16'h001E;
  localparam logic [15:0] OFS_OPT_ONE  = 16'h001F;
  localparam logic [15:0] OFS_WDOG_SVC = 16'hFFFF;

  // Baud source defaults to the bus clock
  localparam logic [7:0] OPT_TWO_RST = 8'h01;
  localparam logic [7:0] OPT_ONE_RST = 8'h00;

  localparam int WDOG_PRE_W    = 12;
  localparam int WDOG_CNT_W    = 6;
  localparam int SVC_KEEP_LSB  = 4;
  localparam int WDOG_PULL_CYC = 32;
  localparam int SHORT_REC_CYC = 32;
  localparam int LONG_REC_CYC  = 4096;
  localparam int POR_CLR_CYC   = 4096;
  localparam int REC_W         = 13;
  localparam int PULL_W        = 6;

  typedef struct packed {
    logic [3:0] unused;
    logic       can_enable;
    logic       timebase_extra_divider;
    logic       osc_run_in_stop;
    logic       serial_baud_source;
  } wocw_opt_two_t;

  typedef struct packed {
    logic watchdog_rate_select;
    logic voltmon_in_stop;
    logic voltmon_reset_disable;
    logic voltmon_power_disable;
    logic voltmon_supply_mode;
    logic short_stop_recovery;
    logic stop_enable;
    logic watchdog_disable;
  } wocw_opt_one_t;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        wr;
    logic        rd;
  } wocw_bus_t;

  typedef enum logic [1:0] {
    WOCW_RUN,
    WOCW_STOP,
    WOCW_REC
  } wocw_state_t;

endpackage

// file: design/wocw_top.sv
// Write-once option registers, stop-mode sequencing and watchdog.
// Assumes rst is power-on reset, other_rst any later internal reset,
// and xtal_tick a one-cycle crystal clock enable on sys_clk.
//
// Contract
// [RQ1] Each option register takes one write per reset; reads always allowed.
// [RQ2] Reset clears option bits except power-on-only ones; here reset sets serial_baud_source to 1 instead.
// [RQ3] Supply-mode bit writable once per power-on; other resets keep it.
// [RQ4] CAN enable cleared only at power-on; set hands module two pins.
// [RQ5] Timebase extra divide-by-128 inserted while its select bit set.
// [RQ6] Oscillator runs in stop only when its bit is set.
// [RQ7] Baud clock from bus clock when bit is 1, oscillator when 0.
// [RQ8] Watchdog timeout 2^13-16 with rate bit 1, 2^18-16 with 0.
// [RQ9] Monitor runs in stop only with stop bit set, power not disabled.
// [RQ10] Monitor resets blocked by reset-disable; power removed by power-disable.
// [RQ11] Supply-mode bit picks 5 V trip points at 1, 3 V at 0.
// [RQ12] Stop recovery 32 crystal cycles when short bit set, else 4096.
// [RQ13] Leaving stop through a monitor reset always uses long recovery.
// [RQ14] Software should not pick short recovery with oscillator off in stop.
// [RQ15] Stop instruction runs when enabled, else it is an illegal opcode.
// [RQ16] Watchdog disabled entirely while its disable bit is 1.
// [RQ17] Watchdog is 6-bit counter on 12-bit crystal prescaler; overflow resets.
// [RQ18] Any write to service address clears counter and prescaler stages 12-5.
// [RQ19] Reads of service address return reset vector low byte.
// [RQ20] Overflow pulls reset pin low 32 crystal cycles, flags watchdog cause.
// [RQ21] Watchdog held off by test voltage in monitor mode or break.
// [RQ22] Stop clears whole prescaler; prescaler cleared 4096 cycles after power-up.
// [RQ23] Internal reset clears watchdog prescaler and counter.
// [RQ24] Reset vector fetch clears watchdog prescaler.
// [RQ25] Per-register written-once flags gate writes; supply flag clears at power-on only.
//
// Decided for this implementation: the plain strobed port.
`timescale 1ns/1ps

module wocw_top
  import wocw_pkg::*;
#(
  parameter int PRE_W     = WDOG_PRE_W,
  parameter int CNT_W     = WDOG_CNT_W,
  parameter int SHORT_REC = SHORT_REC_CYC,
  parameter int LONG_REC  = LONG_REC_CYC
) (
  input  wire logic          sys_clk,
  input  wire logic          rst,
  input  wire logic          clk_en,
  input  wire logic          other_rst,
  input  wire wocw_bus_t     bus_i,
  output      logic [7:0]    rd_data_o,
  input  wire logic          xtal_tick,
  input  wire logic [7:0]    reset_vec_lo,
  input  wire logic          vec_fetch,
  input  wire logic          stop_instr,
  input  wire logic          wake_req,
  input  wire logic          voltmon_trip,
  input  wire logic          monitor_mode,
  input  wire logic          break_state,
  input  wire logic          tst_on_rst,
  input  wire logic          tst_on_irq,
  output wocw_opt_one_t      opt_one_o,
  output wocw_opt_two_t      opt_two_o,
  output      logic          stop_exec_o,
  output      logic          illegal_op_o,
  output      logic          stop_mode_o,
  output      logic          resume_o,
  output      logic          osc_enable_o,
  output      logic          voltmon_power_o,
  output      logic          voltmon_reset_o,
  output      logic          rst_pin_o,
  output      logic          rst_pin_oe_n,
  output      logic          wdog_cause_o
);

  function automatic logic hit(input logic [15:0] a, input logic [15:0] ofs);
    hit = (a == ofs);
  endfunction

  wocw_opt_one_t     opt_one_q;
  wocw_opt_two_t     opt_two_q;
  logic              one_done_q;
  logic              two_done_q;
  logic              sup_done_q;
  logic [7:0]        rd_data_q;
  wocw_state_t       state_q;
  wocw_state_t       state_d;
  logic [REC_W-1:0]  rec_q;
  logic [REC_W-1:0]  rec_d;
  logic              stop_mode_q;
  logic              resume_q;
  logic              stop_exec_q;
  logic              illegal_q;
  logic              osc_en_q;
  logic              vm_pwr_q;
  logic              vm_rst_q;
  logic [PRE_W-1:0]  pre_q;
  logic [CNT_W-1:0]  cnt_q;
  logic [REC_W-1:0]  por_q;
  logic [PULL_W-1:0] pull_q;
  logic [PULL_W-1:0] pull_d;
  logic              oe_n_q;
  logic              cause_q;
  logic [1:0]        pin_raw;
  logic [1:0]        pin_lvl;
  logic              wr_one;
  logic              wr_two;
  logic              svc;
  logic              stop_go;
  logic              lvi_req;
  logic              hold;
  logic              wd_tick;
  logic              pre_wrap;
  logic              wd_ovf;
  logic              por_clr;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  assign wr_one = bus_i.wr && hit(bus_i.addr, OFS_OPT_ONE);
  assign wr_two = bus_i.wr && hit(bus_i.addr, OFS_OPT_TWO);
  assign svc    = bus_i.wr && hit(bus_i.addr, OFS_WDOG_SVC);

  // Test-voltage detectors are analog pins, so filter them
  assign pin_raw = {tst_on_irq, tst_on_rst};
  for (genvar g = 0; g < 2; g++) begin : g_sync
    logic [2:0] s_q;
    logic       lvl_q;
    always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
        s_q   <= 3'h0;
        lvl_q <= 1'b0;
      end else if (clk_en) begin
        s_q <= {s_q[1:0], pin_raw[g]};
        if (s_q[1] == s_q[2]) begin
          lvl_q <= s_q[2];
        end
      end
    end
    assign pin_lvl[g] = lvl_q;
  end

  // Option register one with its own once flag
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      opt_one_q  <= wocw_opt_one_t'(OPT_ONE_RST);
      one_done_q <= 1'b0;
      sup_done_q <= 1'b0;
    end else if (clk_en) begin
      if (other_rst) begin
        opt_one_q                     <= wocw_opt_one_t'(OPT_ONE_RST); // RQ2 RQ8 RQ9
        opt_one_q.voltmon_supply_mode <= opt_one_q.voltmon_supply_mode; // RQ3
        one_done_q                    <= 1'b0; // RQ25
      end else if (wr_one && !one_done_q) begin
        opt_one_q  <= wocw_opt_one_t'(bus_i.wdata); // RQ1
        one_done_q <= 1'b1; // RQ25
        sup_done_q <= 1'b1; // RQ3
        if (sup_done_q) begin
          opt_one_q.voltmon_supply_mode <= opt_one_q.voltmon_supply_mode; // RQ3 RQ11
        end
      end
    end
  end

  // Option register two; CAN enable survives internal resets
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      opt_two_q  <= wocw_opt_two_t'(OPT_TWO_RST);
      two_done_q <= 1'b0;
    end else if (clk_en) begin
      if (other_rst) begin
        opt_two_q            <= wocw_opt_two_t'(OPT_TWO_RST); // RQ2 RQ7
        opt_two_q.can_enable <= opt_two_q.can_enable; // RQ4
        two_done_q           <= 1'b0; // RQ25
      end else if (wr_two && !two_done_q) begin
        opt_two_q        <= wocw_opt_two_t'(bus_i.wdata); // RQ1 RQ4 RQ5 RQ7
        opt_two_q.unused <= 4'h0;
        two_done_q       <= 1'b1; // RQ25
      end
    end
  end

  // Read data stands for one cycle only
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rd_data_q <= 8'h00;
    end else if (clk_en) begin
      rd_data_q <= 8'h00;
      if (bus_i.rd) begin
        if (hit(bus_i.addr, OFS_OPT_ONE)) begin
          rd_data_q <= opt_one_q; // RQ1
        end else if (hit(bus_i.addr, OFS_OPT_TWO)) begin
          rd_data_q <= opt_two_q; // RQ1
        end else if (hit(bus_i.addr, OFS_WDOG_SVC)) begin
          rd_data_q <= reset_vec_lo; // RQ19
        end
      end
    end
  end

  assign stop_go = stop_instr && opt_one_q.stop_enable && (state_q == WOCW_RUN); // RQ15
  assign lvi_req = voltmon_trip && !opt_one_q.voltmon_reset_disable
                   && !opt_one_q.voltmon_power_disable; // RQ10

  always_comb begin
    state_d = state_q;
    rec_d   = rec_q;
    unique case (state_q)
      WOCW_RUN: begin
        if (stop_go) begin
          state_d = WOCW_STOP;
        end
      end
      WOCW_STOP: begin
        if (lvi_req) begin
          state_d = WOCW_REC;
          rec_d   = REC_W'(LONG_REC); // RQ13
        end else if (wake_req) begin
          state_d = WOCW_REC;
          rec_d   = opt_one_q.short_stop_recovery ? REC_W'(SHORT_REC) : REC_W'(LONG_REC); // RQ12
        end
      end
      WOCW_REC: begin
        if (xtal_tick) begin
          rec_d = rec_q - REC_W'(1);
          if (rec_q == REC_W'(1)) begin
            state_d = WOCW_RUN; // RQ12
          end
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_q     <= WOCW_RUN;
      rec_q       <= '0;
      stop_mode_q <= 1'b0;
      resume_q    <= 1'b0;
      stop_exec_q <= 1'b0;
      illegal_q   <= 1'b0;
    end else if (clk_en) begin
      state_q     <= state_d;
      rec_q       <= rec_d;
      stop_mode_q <= (state_d != WOCW_RUN);
      resume_q    <= (state_q == WOCW_REC) && (state_d == WOCW_RUN);
      stop_exec_q <= stop_go; // RQ15
      illegal_q   <= stop_instr && !opt_one_q.stop_enable; // RQ15
    end
  end

  // Oscillator and monitor power follow the next stop state; monitor reset follows lvi_req
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      osc_en_q <= 1'b1;
      vm_pwr_q <= 1'b1;
      vm_rst_q <= 1'b0;
    end else if (clk_en) begin
      osc_en_q <= (state_d == WOCW_RUN) || opt_two_q.osc_run_in_stop; // RQ6
      vm_pwr_q <= !opt_one_q.voltmon_power_disable
                  && ((state_d == WOCW_RUN) || opt_one_q.voltmon_in_stop); // RQ9 RQ10
      vm_rst_q <= lvi_req; // RQ10
    end
  end

  // Watchdog has no crystal clock in stop
  assign hold     = (monitor_mode && (pin_lvl[0] || pin_lvl[1]))
                    || (break_state && pin_lvl[0]); // RQ21
  assign wd_tick  = xtal_tick && !opt_one_q.watchdog_disable && !hold
                    && (state_q == WOCW_RUN); // RQ16 RQ21
  assign pre_wrap = wd_tick && (&pre_q); // RQ17
  // Service in the overflow cycle wins, so a late service still saves the part
  assign wd_ovf   = pre_wrap && !svc && !other_rst
                    && (opt_one_q.watchdog_rate_select ? cnt_q[0] : (&cnt_q)); // RQ8 RQ17
  assign por_clr  = xtal_tick && (por_q == REC_W'(POR_CLR_CYC - 1)); // RQ22

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      por_q <= '0;
    end else if (clk_en) begin
      if (xtal_tick && (por_q != REC_W'(POR_CLR_CYC))) begin
        por_q <= por_q + REC_W'(1);
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pre_q <= '0;
    end else if (clk_en) begin
      if (other_rst || stop_go || vec_fetch || por_clr) begin
        pre_q <= '0; // RQ22 RQ23 RQ24
      end else if (svc) begin
        pre_q[PRE_W-1:SVC_KEEP_LSB] <= '0; // RQ18
      end else if (wd_tick) begin
        pre_q <= pre_q + PRE_W'(1); // RQ17
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cnt_q <= '0;
    end else if (clk_en) begin
      if (other_rst || svc || wd_ovf) begin
        cnt_q <= '0; // RQ18 RQ23
      end else if (pre_wrap) begin
        cnt_q <= cnt_q + CNT_W'(1); // RQ17
      end
    end
  end

  always_comb begin
    pull_d = pull_q;
    if (wd_ovf) begin
      pull_d = PULL_W'(WDOG_PULL_CYC); // RQ20
    end else if (xtal_tick && (pull_q != '0)) begin
      pull_d = pull_q - PULL_W'(1);
    end
  end

  // Pin pull is not cut short by the reset it causes
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pull_q  <= '0;
      oe_n_q  <= 1'b1;
      cause_q <= 1'b0;
    end else if (clk_en) begin
      pull_q  <= pull_d;
      oe_n_q  <= (pull_d == '0); // RQ20
      cause_q <= wd_ovf; // RQ20
    end
  end

  assign rd_data_o       = rd_data_q;
  assign opt_one_o       = opt_one_q;
  assign opt_two_o       = opt_two_q;
  assign stop_exec_o     = stop_exec_q;
  assign illegal_op_o    = illegal_q;
  assign stop_mode_o     = stop_mode_q;
  assign resume_o        = resume_q;
  assign osc_enable_o    = osc_en_q;
  assign voltmon_power_o = vm_pwr_q;
  assign voltmon_reset_o = vm_rst_q;
  assign rst_pin_o       = oe_n_q;
  assign rst_pin_oe_n    = oe_n_q;
  assign wdog_cause_o    = cause_q;

  property p_once_one;
    clk_en && one_done_q && wr_one && !other_rst |=> $stable(opt_one_q);
  endproperty
  a_once_one: assert property (p_once_one) else $error("option one rewritten"); // RQ1

  property p_rst_clear;
    clk_en && other_rst |=> !opt_one_q.watchdog_rate_select && !opt_one_q.voltmon_in_stop
                            && !one_done_q && !two_done_q && (cnt_q == '0) && (pre_q == '0);
  endproperty
  a_rst_clear: assert property (p_rst_clear) else $error("reset left option bits"); // RQ2 RQ23

  property p_supply_keep;
    clk_en && other_rst |=> $stable(opt_one_q.voltmon_supply_mode) && $stable(sup_done_q);
  endproperty
  a_supply_keep: assert property (p_supply_keep) else $error("supply mode lost"); // RQ3

  property p_can_keep;
    clk_en && other_rst |=> $stable(opt_two_q.can_enable);
  endproperty
  a_can_keep: assert property (p_can_keep) else $error("can enable lost"); // RQ4

  property p_illegal;
    clk_en && stop_instr && !opt_one_q.stop_enable |=> illegal_op_o && !stop_exec_o && !stop_mode_o;
  endproperty
  a_illegal: assert property (p_illegal) else $error("disabled stop executed"); // RQ15

  property p_svc;
    clk_en && svc && !other_rst |=> (cnt_q == '0) && (pre_q[PRE_W-1:SVC_KEEP_LSB] == '0);
  endproperty
  a_svc: assert property (p_svc) else $error("service did not clear"); // RQ18

  property p_pull;
    clk_en && wd_ovf |=> !rst_pin_oe_n && wdog_cause_o && (pull_q == PULL_W'(WDOG_PULL_CYC));
  endproperty
  a_pull: assert property (p_pull) else $error("watchdog pull wrong"); // RQ20

  property p_disable;
    clk_en && opt_one_q.watchdog_disable && !other_rst && !svc |=> $stable(cnt_q) && !wdog_cause_o;
  endproperty
  a_disable: assert property (p_disable) else $error("disabled watchdog ran"); // RQ16

  property p_stop_clr;
    clk_en && stop_go |=> (pre_q == '0) && stop_mode_o;
  endproperty
  a_stop_clr: assert property (p_stop_clr) else $error("stop kept prescaler"); // RQ22

  property p_lvi_long;
    clk_en && (state_q == WOCW_STOP) && lvi_req |=> rec_q == REC_W'(LONG_REC);
  endproperty
  a_lvi_long: assert property (p_lvi_long) else $error("monitor exit not long"); // RQ13

  property p_osc;
    stop_mode_o && !opt_two_q.osc_run_in_stop && !$changed(opt_two_q) |-> !osc_enable_o;
  endproperty
  a_osc: assert property (p_osc) else $error("oscillator ran in stop"); // RQ6

  property p_rd_vec;
    clk_en && bus_i.rd && hit(bus_i.addr, OFS_WDOG_SVC) |=> rd_data_o == $past(reset_vec_lo);
  endproperty
  a_rd_vec: assert property (p_rd_vec) else $error("service read wrong"); // RQ19

endmodule // wocw_top

// file: tb/wocw_top_bench.sv
// Self-checking bench for the write-once option bank and watchdog.
// Assumes wocw_pkg is compiled first; drives wocw_top directly.
`timescale 1ns/1ps

module wocw_top_bench;
  import wocw_pkg::*;

  localparam int PW = 6;
  localparam int SR = 8;
  localparam int LR = 64;

  logic          sys_clk   = 1'b0;
  logic          rst       = 1'b1;
  logic          oth       = 1'b0;
  logic          xtal_tick = 1'b0;
  logic          stop_i    = 1'b0;
  logic          wake      = 1'b0;
  logic          trip      = 1'b0;
  logic          mon       = 1'b0;
  logic          tirq      = 1'b0;
  logic          brk       = 1'b0;
  logic          trst      = 1'b0;
  logic          vf        = 1'b0;
  logic          rd_seen   = 1'b0;
  logic [7:0]    vec       = 8'h00;
  wocw_bus_t     bus       = '0;
  logic [7:0]    rd_data;
  wocw_opt_one_t o1;
  wocw_opt_two_t o2;
  logic          sx, ill, sm, res, osc, vpw, vrs, pin, oe_n, cause;
  logic [7:0]    exp_q[$];
  logic [7:0]    a, b;
  int            fail_count = 0;
  int            n_tests    = 0;
  int            n_cause    = 0;
  int            c, t;

  always #10 sys_clk = ~sys_clk;

  // Crystal tick every other bus cycle
  always @(posedge sys_clk) xtal_tick <= ~xtal_tick;

  wocw_top #(.PRE_W(PW), .CNT_W(WDOG_CNT_W), .SHORT_REC(SR), .LONG_REC(LR)) u_wocw_top (
    .sys_clk(sys_clk), .rst(rst), .clk_en(1'b1), .other_rst(oth), .bus_i(bus),
    .rd_data_o(rd_data), .xtal_tick(xtal_tick), .reset_vec_lo(vec), .vec_fetch(vf),
    .stop_instr(stop_i), .wake_req(wake), .voltmon_trip(trip), .monitor_mode(mon),
    .break_state(brk), .tst_on_rst(trst), .tst_on_irq(tirq), .opt_one_o(o1),
    .opt_two_o(o2), .stop_exec_o(sx), .illegal_op_o(ill), .stop_mode_o(sm),
    .resume_o(res), .osc_enable_o(osc), .voltmon_power_o(vpw), .voltmon_reset_o(vrs),
    .rst_pin_o(pin), .rst_pin_oe_n(oe_n), .wdog_cause_o(cause)
  );

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic rng(input int v, input int lo, input int hi, input string m);
    n_tests++;
    if (v < lo || v > hi) begin
      fail_count++;
      $display("MISMATCH %0t %s count %0d not in %0d..%0d", $time, m, v, lo, hi);
    end
  endtask

  // Read result is checked one cycle later by the watcher below
  always @(posedge sys_clk) begin
    if (rd_seen) begin
      if (exp_q.size() == 0) chk(rd_data, 8'h00, "unexpected read");
      else chk(rd_data, exp_q.pop_front(), "read data");
    end
    rd_seen <= bus.rd;
    // Any watchdog reset is counted, so quiet stretches can be checked
    if (cause === 1'b1) begin
      n_cause++;
    end
  end

  task automatic wr(input logic [15:0] ad, input logic [7:0] d);
    @(posedge sys_clk);
    bus.addr  <= ad;
    bus.wdata <= d;
    bus.wr    <= 1'b1;
    @(posedge sys_clk);
    bus.wr    <= 1'b0;
  endtask

  task automatic rd(input logic [15:0] ad, input logic [7:0] e);
    exp_q.push_back(e);
    @(posedge sys_clk);
    bus.addr <= ad;
    bus.rd   <= 1'b1;
    @(posedge sys_clk);
    bus.rd   <= 1'b0;
  endtask

  task automatic por();
    @(posedge sys_clk);
    rst <= 1'b1;
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    @(negedge sys_clk);
  endtask

  task automatic pulse_stop();
    @(posedge sys_clk);
    stop_i <= 1'b1;
    @(posedge sys_clk);
    stop_i <= 1'b0;
    @(negedge sys_clk);
  endtask

  // Bounded wait on resume (w=0) or watchdog cause (w=1)
  task automatic wt(input int w, input int lim, input bit must, output int n);
    n = 0;
    do begin
      @(negedge sys_clk);
      n++;
    end while (n < lim && (w ? cause : res) !== 1'b1);
    if (must && n >= lim) begin
      fail_count++;
      $display("MISMATCH %0t wait ran out", $time);
      print_verdict();
    end
  endtask

  initial begin
    void'($urandom(65421));
    vec = 8'($urandom);
    por();
    rd(OFS_OPT_ONE, OPT_ONE_RST);
    rd(OFS_OPT_TWO, OPT_TWO_RST);
    a = 8'($urandom);
    b = 8'($urandom);
    wr(OFS_OPT_ONE, a);
    wr(OFS_OPT_ONE, ~a);
    rd(OFS_OPT_ONE, a);
    wr(OFS_OPT_TWO, b);
    wr(OFS_OPT_TWO, ~b);
    rd(OFS_OPT_TWO, b & 8'h0F);
    rd(16'h1234, 8'h00);
    wr(OFS_WDOG_SVC, ~vec);
    rd(OFS_WDOG_SVC, vec);
    @(posedge sys_clk);
    oth <= 1'b1;
    @(posedge sys_clk);
    oth <= 1'b0;
    @(negedge sys_clk);
    chk(o1, a & 8'h08, "opt one after reset");
    chk(o2, 8'h01 | (b & 8'h08), "opt two after reset");
    wr(OFS_OPT_ONE, ~a);
    @(negedge sys_clk);
    chk(o1, (~a & 8'hF7) | (a & 8'h08), "supply bit kept");
    por();
    chk(o1, OPT_ONE_RST, "opt one power-on");
    chk(o2, OPT_TWO_RST, "opt two power-on");
    $display("test registers done");

    wr(OFS_OPT_ONE, 8'hC7);
    wr(OFS_OPT_TWO, 8'h0F);
    @(negedge sys_clk);
    chk(o2, 8'h0F, "opt two controls");
    chk(vpw, 1'b1, "monitor power");
    pulse_stop();
    chk({sx, sm, osc}, 3'b111, "stop entry");
    chk(vpw, 1'b1, "monitor kept in stop");
    @(posedge sys_clk);
    wake <= 1'b1;
    wt(0, 400, 1, c);
    rng(c, 2 * SR - 3, 2 * SR + 4, "short recovery");
    chk(sm, 1'b0, "stop left");
    @(posedge sys_clk);
    wake <= 1'b0;
    pulse_stop();
    @(posedge sys_clk);
    trip <= 1'b1;
    wt(0, 400, 1, c);
    rng(c, 2 * LR - 3, 2 * LR + 4, "monitor recovery");
    chk(vrs, 1'b1, "monitor reset passes");
    @(posedge sys_clk);
    trip <= 1'b0;
    wt(1, 600, 0, c);
    rng(c, 600, 600, "watchdog disabled");
    $display("test stop done");

    // Runs 2 and 3 hold the watchdog by test voltage, monitor then break
    for (int i = 0; i < 4; i++) begin
      por();
      @(posedge sys_clk);
      mon  <= (i == 2);
      tirq <= (i == 2);
      trip <= (i == 2);
      brk  <= (i == 3);
      trst <= (i == 3);
      wr(OFS_OPT_ONE, (i == 1) ? 8'h00 : ((i == 2) ? 8'hB0 : 8'h80));
      c = n_cause;
      // Keep servicing past the power-on prescaler clear
      repeat (85) begin
        wr(OFS_WDOG_SVC, 8'($urandom));
        repeat (100) @(posedge sys_clk);
      end
      rng(n_cause - c, 0, 0, "serviced watchdog quiet");
      t = (i == 1) ? (1 << (PW + 6)) : (1 << (PW + 1));
      wr(OFS_WDOG_SVC, 8'h00);
      if (i >= 2) begin
        wt(1, 2 * t + 200, 0, c);
        rng(c, 2 * t + 200, 2 * t + 200, "watchdog held");
        if (i == 2) begin
          chk({vrs, vpw}, 2'b00, "monitor reset and power off");
        end
      end else begin
        wt(1, 2 * t + 200, 1, c);
        rng(c, 2 * (t - 16) - 4, 2 * t + 4, "watchdog timeout");
        @(negedge sys_clk);
        chk({pin, oe_n, cause}, 3'b000, "pin pull");
        c = 1;
        while (oe_n === 1'b0 && c < 200) begin
          @(negedge sys_clk);
          c++;
        end
        rng(c, 2 * WDOG_PULL_CYC - 2, 2 * WDOG_PULL_CYC + 2, "pull length");
        if (i == 0) begin
          // Fetch held high keeps the prescaler at zero, so no overflow
          @(posedge sys_clk);
          vf <= 1'b1;
          wt(1, 2 * t + 200, 0, c);
          rng(c, 2 * t + 200, 2 * t + 200, "fetch holds prescaler");
          @(posedge sys_clk);
          vf <= 1'b0;
        end
      end
      if (i == 1) begin
        pulse_stop();
        chk({ill, sx}, 2'b10, "stop refused");
      end
    end
    @(posedge sys_clk);
    brk  <= 1'b0;
    trst <= 1'b0;
    $display("test watchdog done");
    repeat (4) @(posedge sys_clk);
    print_verdict();
  end
endmodule // wocw_top_bench
